// [rtl/pkc_knob_ctrl.sv]
`timescale 1ns/1ns
`include "pkc_map.svh"
module pkc_knob_ctrl #(
    parameter int unsigned BURST_CYC = `PKC_BURST_NS / `PKC_CLK_NS,
    parameter int unsigned FLASH_CYC = `PKC_FLASH_NS / `PKC_CLK_NS
) (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Knob pins
    input wire logic knob_press,
    input wire logic knob_up,
    input wire logic knob_down,
    // Speed loop status
    input wire logic [15:0] rpm_meas,
    input wire logic [15:0] servo_current,
    // Outputs
    output logic pitch_hold,
    output logic pitch_fine,
    output logic pitch_stop,
    output logic sync_led,
    output logic dots_on,
    output logic dim_on,
    output logic state_led_green,
    output logic [15:0] display_value
);
    // ----------------------------------------
    // Pin synchronisers and edges
    // ----------------------------------------
    logic press_s, up_s, down_s;
    logic press_d, up_d, down_d;
    pkc_sync u_sp (.pclk(pclk), .presetn(presetn), .din(knob_press), .dout(press_s));
    pkc_sync u_su (.pclk(pclk), .presetn(presetn), .din(knob_up), .dout(up_s));
    pkc_sync u_sd (.pclk(pclk), .presetn(presetn), .din(knob_down), .dout(down_s));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            press_d <= 1'b0;
            up_d <= 1'b0;
            down_d <= 1'b0;
        end else begin
            press_d <= press_s;
            up_d <= up_s;
            down_d <= down_s;
        end
    end
    logic press_ev, up_ev, down_ev;
    assign press_ev = press_s & ~press_d;
    assign up_ev = up_s & ~up_d;
    assign down_ev = down_s & ~down_d;

    // ----------------------------------------
    // Burst grouping
    // ----------------------------------------
    logic burst_run, burst_done, flash_run;
    logic [2:0] burst_cnt, next_burst_cnt;
    logic restore_go;
    pkc_timer #(.LEN(BURST_CYC)) u_burst (.pclk(pclk), .presetn(presetn),
        .start(press_ev), .running(burst_run), .expired(burst_done));
    pkc_timer #(.LEN(FLASH_CYC)) u_flash (.pclk(pclk), .presetn(presetn),
        .start(restore_go), .running(flash_run), .expired());
    always_comb begin
        next_burst_cnt = burst_cnt;
        if (burst_done) begin
            next_burst_cnt = 3'h0;
        end
        if (press_ev && burst_cnt != 3'h7) begin
            next_burst_cnt = (burst_done ? 3'h0 : burst_cnt) + 3'h1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_cnt <= 3'h0;
        end else begin
            burst_cnt <= next_burst_cnt;
        end
    end
    logic act1, act2, act4, act5;
    assign act1 = burst_done && burst_cnt == 3'h1;
    assign act2 = burst_done && burst_cnt == 3'h2;
    assign act4 = burst_done && burst_cnt == 3'h4;
    assign act5 = burst_done && burst_cnt == 3'h5;

    // ----------------------------------------
    // Mode, parameters, selection
    // ----------------------------------------
    pkc_pkg::pkc_mode_t mode, next_mode;
    pkc_pkg::pkc_param_t step, next_step;
    logic [15:0] ga, rl, pstop, tach, sel, rpm_reg;
    logic [15:0] next_ga, next_rl, next_pstop, next_tach, next_sel;
    logic tachen, next_tachen, dim, next_dim, synced, next_synced;
    logic [15:0] c_ga, c_rl, c_pstop, c_tach;
    logic [15:0] next_c_ga, next_c_rl, next_c_pstop, next_c_tach;
    logic c_tachen, next_c_tachen;
    logic wr_en, sel_wr;
    logic [15:0] wr_val;
    assign wr_en = psel & penable & pwrite;
    assign sel_wr = wr_en && paddr == `PKC_OFF_SEL;
    assign wr_val = pwdata[15:0];
    assign restore_go = act5 && mode != pkc_pkg::PKC_CAL;
    always_comb begin
        next_mode = mode;
        next_step = step;
        next_ga = ga;
        next_rl = rl;
        next_pstop = pstop;
        next_tach = tach;
        next_tachen = tachen;
        next_c_ga = c_ga;
        next_c_rl = c_rl;
        next_c_pstop = c_pstop;
        next_c_tach = c_tach;
        next_c_tachen = c_tachen;
        next_sel = sel;
        next_dim = dim;
        next_synced = synced;
        if (act2) begin
            next_dim = ~dim;
        end
        if (mode == pkc_pkg::PKC_CAL) begin
            if (up_ev || down_ev) begin
                case (step)
                    pkc_pkg::PKC_P_GA: begin
                        if (up_ev && c_ga < c_rl) next_c_ga = c_ga + `PKC_ONE;
                        if (down_ev && c_ga != 16'h0000) next_c_ga = c_ga - `PKC_ONE;
                    end
                    pkc_pkg::PKC_P_RL: begin
                        if (up_ev && c_rl < `PKC_RL_MAX) next_c_rl = c_rl + `PKC_ONE;
                        if (down_ev && c_rl > `PKC_RL_MIN && c_rl > c_ga) begin
                            next_c_rl = c_rl - `PKC_ONE;
                        end
                    end
                    pkc_pkg::PKC_P_PSTOP: begin
                        if (up_ev && c_pstop != 16'hFFFF) next_c_pstop = c_pstop + `PKC_ONE;
                        if (down_ev && c_pstop != 16'h0000) next_c_pstop = c_pstop - `PKC_ONE;
                    end
                    pkc_pkg::PKC_P_TACH: begin
                        if (up_ev && c_tach <= 16'hFFFF - `PKC_TACH_STEP) begin
                            next_c_tach = c_tach + `PKC_TACH_STEP;
                        end
                        if (down_ev && c_tach >= `PKC_TACH_STEP) begin
                            next_c_tach = c_tach - `PKC_TACH_STEP;
                        end
                    end
                    pkc_pkg::PKC_P_TACHEN: begin
                        next_c_tachen = up_ev;
                    end
                    default: begin
                        next_c_ga = c_ga;
                    end
                endcase
            end
            if (act1) begin
                if (step == pkc_pkg::PKC_P_TACHEN) begin
                    next_mode = pkc_pkg::PKC_GOV;
                    next_ga = c_ga;
                    next_rl = c_rl;
                    next_pstop = c_pstop;
                    next_tach = c_tach;
                    next_tachen = c_tachen;
                    next_sel = (sel > c_rl) ? c_rl : sel;
                end else begin
                    next_step = pkc_pkg::pkc_param_t'(step + 3'h1);
                end
            end
        end else begin
            if (act1) begin
                next_mode = (mode == pkc_pkg::PKC_ADJ) ? pkc_pkg::PKC_GOV
                    : pkc_pkg::PKC_ADJ;
                next_synced = 1'b0;
            end
            if (act4) begin
                next_mode = pkc_pkg::PKC_CAL;
                next_step = pkc_pkg::PKC_P_GA;
                next_c_ga = ga;
                next_c_rl = rl;
                next_c_pstop = pstop;
                next_c_tach = tach;
                next_c_tachen = tachen;
            end
            if (restore_go) begin
                next_ga = `PKC_DEF_GA;
                next_rl = `PKC_DEF_RL;
                next_pstop = `PKC_DEF_PSTOP;
                next_tach = `PKC_DEF_TACH;
                next_tachen = `PKC_DEF_TACHEN;
                next_sel = `PKC_DEF_GA;
            end
            if (up_ev && sel < rl) begin
                next_sel = sel + `PKC_ONE;
                next_synced = 1'b0;
            end else if (down_ev && sel != 16'h0000) begin
                next_sel = sel - `PKC_ONE;
                next_synced = 1'b0;
            end
            if (sel_wr) begin
                next_sel = (wr_val > rl) ? rl : wr_val;
                next_synced = 1'b0;
            end
            // A new target or a single-press mode change this cycle outranks a match on the old one
            if (mode == pkc_pkg::PKC_ADJ && rpm_reg == sel && !act1 && !restore_go
                    && !up_ev && !down_ev && !sel_wr) begin
                next_synced = 1'b1;
            end
            if (rpm_reg > rl) begin
                next_synced = 1'b0;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= pkc_pkg::PKC_GOV;
            step <= pkc_pkg::PKC_P_GA;
            ga <= `PKC_DEF_GA;
            rl <= `PKC_DEF_RL;
            pstop <= `PKC_DEF_PSTOP;
            tach <= `PKC_DEF_TACH;
            tachen <= `PKC_DEF_TACHEN;
            c_ga <= `PKC_DEF_GA;
            c_rl <= `PKC_DEF_RL;
            c_pstop <= `PKC_DEF_PSTOP;
            c_tach <= `PKC_DEF_TACH;
            c_tachen <= `PKC_DEF_TACHEN;
            sel <= `PKC_DEF_GA;
            dim <= 1'b0;
            synced <= 1'b0;
            rpm_reg <= 16'h0000;
        end else begin
            mode <= next_mode;
            step <= next_step;
            ga <= next_ga;
            rl <= next_rl;
            pstop <= next_pstop;
            tach <= next_tach;
            tachen <= next_tachen;
            c_ga <= next_c_ga;
            c_rl <= next_c_rl;
            c_pstop <= next_c_pstop;
            c_tach <= next_c_tach;
            c_tachen <= next_c_tachen;
            sel <= next_sel;
            dim <= next_dim;
            synced <= next_synced;
            rpm_reg <= rpm_meas;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic [19:0] stop_lim;
    assign stop_lim = {4'h0, pstop} * {16'h0000, `PKC_FAST_FACT};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pitch_hold <= 1'b1;
            pitch_fine <= 1'b0;
            pitch_stop <= 1'b0;
            sync_led <= 1'b0;
            dots_on <= 1'b0;
            dim_on <= 1'b0;
            state_led_green <= 1'b1;
            display_value <= 16'h0000;
        end else begin
            // Calibration freezes the loop; sync in adjustable mode too
            pitch_hold <= mode == pkc_pkg::PKC_CAL
                || (mode == pkc_pkg::PKC_ADJ && synced);
            pitch_fine <= mode == pkc_pkg::PKC_GOV && rpm_reg < sel;
            pitch_stop <= {4'h0, servo_current} > stop_lim;
            sync_led <= synced;
            dots_on <= mode == pkc_pkg::PKC_ADJ;
            dim_on <= dim;
            // Flash while defaults are restored
            state_led_green <= mode != pkc_pkg::PKC_CAL && !flash_run;
            if (mode == pkc_pkg::PKC_CAL) begin
                case (step)
                    pkc_pkg::PKC_P_GA: display_value <= c_ga;
                    pkc_pkg::PKC_P_RL: display_value <= c_rl;
                    pkc_pkg::PKC_P_PSTOP: display_value <= c_pstop;
                    pkc_pkg::PKC_P_TACH: display_value <= c_tach;
                    default: display_value <= {15'h0000, c_tachen};
                endcase
            end else begin
                display_value <= tachen ? rpm_reg : sel;
            end
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign pready = 1'b1;
    always_comb begin
        pslverr = 1'b0;
        case (paddr)
            `PKC_OFF_CTRL: prdata = {30'h0000_0000, mode};
            `PKC_OFF_STATUS: prdata = {26'h0000_000, pitch_stop, pitch_hold, sync_led,
                dots_on, dim_on, state_led_green};
            `PKC_OFF_SEL: prdata = {16'h0000, sel};
            `PKC_OFF_GA: prdata = {16'h0000, ga};
            `PKC_OFF_RL: prdata = {16'h0000, rl};
            `PKC_OFF_PSTOP: prdata = {16'h0000, pstop};
            `PKC_OFF_TACH: prdata = {16'h0000, tach};
            `PKC_OFF_TACHEN: prdata = {31'h0000_0000, tachen};
            `PKC_OFF_RPM: prdata = {16'h0000, rpm_reg};
            default: begin
                prdata = 32'h0000_0000;
                pslverr = psel & penable;
            end
        endcase
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_cal_holds: assert property (@(posedge pclk) disable iff (!presetn)
        mode == pkc_pkg::PKC_CAL |=> pitch_hold) else $error("pitch not held in cal");
    chk_rl_bounds: assert property (@(posedge pclk) disable iff (!presetn)
        rl <= `PKC_RL_MAX && rl >= `PKC_RL_MIN) else $error("redline out of range");
    chk_ga_le_rl: assert property (@(posedge pclk) disable iff (!presetn)
        c_ga <= c_rl) else $error("go-around above redline");
    chk_sel_le_rl: assert property (@(posedge pclk) disable iff (!presetn)
        mode != pkc_pkg::PKC_CAL |-> sel <= rl) else $error("selection above redline");
    chk_dim_toggle: assert property (@(posedge pclk) disable iff (!presetn)
        act2 |=> ##1 dim_on != $past(dim_on)) else $error("dim not toggled");
    chk_cal_entry: assert property (@(posedge pclk) disable iff (!presetn)
        act4 && mode != pkc_pkg::PKC_CAL |=> mode == pkc_pkg::PKC_CAL
        && step == pkc_pkg::PKC_P_GA) else $error("cal not entered");
    chk_adj_exit: assert property (@(posedge pclk) disable iff (!presetn)
        act1 && mode == pkc_pkg::PKC_ADJ |=> ##1 !dots_on) else $error("dots not cleared");
    chk_sync_off: assert property (@(posedge pclk) disable iff (!presetn)
        sel_wr && mode != pkc_pkg::PKC_CAL |=> ##1 !sync_led) else $error("sync stayed on");
    chk_restore_flash: assert property (@(posedge pclk) disable iff (!presetn)
        restore_go |=> ##1 !state_led_green) else $error("no flash on restore");
endmodule

// [common/pkc_map.svh]
`ifndef PKC_MAP_SVH
`define PKC_MAP_SVH
// Register byte offsets
`define PKC_OFF_CTRL      12'h000
`define PKC_OFF_STATUS    12'h004
`define PKC_OFF_SEL       12'h008
`define PKC_OFF_GA        12'h00C
`define PKC_OFF_RL        12'h010
`define PKC_OFF_PSTOP     12'h014
`define PKC_OFF_TACH      12'h018
`define PKC_OFF_TACHEN    12'h01C
`define PKC_OFF_RPM       12'h020
// Factory defaults and limits
`define PKC_DEF_GA        16'h09C4
`define PKC_DEF_RL        16'h0A8C
`define PKC_RL_MAX        16'h0B54
`define PKC_RL_MIN        16'h07D0
`define PKC_DEF_PSTOP     16'h005A
`define PKC_DEF_TACH      16'h01F4
`define PKC_TACH_STEP     16'h0005
`define PKC_DEF_TACHEN    1'b1
// Timing, stop-current factor and unit step
`define PKC_BURST_NS      250000000
`define PKC_FLASH_NS      200000000
`define PKC_CLK_NS        8
`define PKC_FAST_FACT     4'h7
`define PKC_ONE           16'h0001
`endif

// [common/pkc_pkg.sv]
package pkc_pkg;
    typedef enum logic [1:0] {PKC_GOV, PKC_ADJ, PKC_CAL} pkc_mode_t;
    typedef enum logic [2:0] {PKC_P_GA, PKC_P_RL, PKC_P_PSTOP, PKC_P_TACH, PKC_P_TACHEN}
        pkc_param_t;
endpackage

// [rtl/pkc_sync.sv]
`timescale 1ns/1ns
module pkc_sync (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Level
    input wire logic din,
    output logic dout
);
    logic stage1;
    logic stage2;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
        end
    end
    assign dout = stage2;
endmodule

// [rtl/pkc_timer.sv]
`timescale 1ns/1ns
module pkc_timer #(
    parameter int unsigned LEN = 32'd10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic start,
    output logic running,
    output logic expired
);
    logic [31:0] count;
    logic [31:0] next_count;
    logic next_expired;
    always_comb begin
        next_count = count;
        next_expired = 1'b0;
        if (start) begin
            next_count = LEN;
        end else if (count != 32'h0000_0000) begin
            next_count = count - 32'h0000_0001;
            next_expired = (count == 32'h0000_0001);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 32'h0000_0000;
            expired <= 1'b0;
        end else begin
            count <= next_count;
            expired <= next_expired;
        end
    end
    assign running = (count != 32'h0000_0000);
endmodule

// [tb/pkc_knob_model.sv]
`timescale 1ns/1ns
module pkc_knob_model (
    // Clock
    input wire logic pclk,
    // Knob pins
    output logic knob_press,
    output logic knob_up,
    output logic knob_down
);
    initial begin
        knob_press = 1'b0;
        knob_up = 1'b0;
        knob_down = 1'b0;
    end
    // Short pulses keep every press of a burst well inside the grouping window
    task automatic press_burst(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            knob_press <= 1'b1;
            repeat (3) @(posedge pclk);
            knob_press <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask
    task automatic turn(input logic up, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            knob_up <= up;
            knob_down <= !up;
            repeat (3) @(posedge pclk);
            knob_up <= 1'b0;
            knob_down <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask
endmodule

// [tb/prop_knob_mode_calibration_control_tb_top.sv]
`timescale 1ns/1ns
`include "pkc_map.svh"
module prop_knob_mode_calibration_control_tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, knob_press, knob_up, knob_down;
    logic [15:0] rpm_meas = 16'h0000, servo_current = 16'h0000, display_value;
    logic pitch_hold, pitch_fine, pitch_stop, sync_led, dots_on, dim_on, state_led_green;
    int num_errors = 0, comparisons = 0;
    always #4 pclk = ~pclk;
    pkc_knob_ctrl #(.BURST_CYC(20), .FLASH_CYC(20)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .knob_press(knob_press),
        .knob_up(knob_up), .knob_down(knob_down), .rpm_meas(rpm_meas),
        .servo_current(servo_current), .pitch_hold(pitch_hold), .pitch_fine(pitch_fine),
        .pitch_stop(pitch_stop), .sync_led(sync_led), .dots_on(dots_on), .dim_on(dim_on),
        .state_led_green(state_led_green), .display_value(display_value));
    pkc_knob_model knob (.pclk(pclk), .knob_press(knob_press), .knob_up(knob_up),
        .knob_down(knob_down));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic complete_run;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        int i;
        logic rdy;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        // Read half a cycle early: that is what stands at the sampling edge
        do begin
            @(negedge pclk);
            rdy = pready;
            rd = prdata;
            err = pslverr;
            @(posedge pclk);
            i++;
        end while (rdy !== 1'b1 && i < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (rdy !== 1'b1) begin
            num_errors++;
            $display("ERROR at %0t: no pready", $time);
            complete_run();
        end
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        check(rd, exp);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask
    // Burst is acted on only after the idle window has run out
    task automatic press(input int n);
        knob.press_burst(n);
        repeat (32) @(posedge pclk);
    endtask
    task automatic turn(input logic up, input int n);
        knob.turn(up, n);
        repeat (4) @(posedge pclk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        logic [31:0] rd;
        logic err;
        check(state_led_green, 1'b1);
        rd_chk(`PKC_OFF_SEL, 32'h0000_09C4);
        rd_chk(`PKC_OFF_RL, 32'h0000_0A8C);
        rd_chk(`PKC_OFF_PSTOP, 32'h0000_005A);
        rd_chk(`PKC_OFF_TACH, 32'h0000_01F4);
        rd_chk(`PKC_OFF_TACHEN, 32'h0000_0001);
        rd_chk(`PKC_OFF_STATUS, 32'h0000_0001);
        apb(1'b0, 12'h0FC, 32'h0000_0000, rd, err);
        check(rd, 32'h0000_0000);
        check(err, 1'b1);
    endtask
    task automatic t_gov;
        rpm_meas <= 16'h03E8;
        servo_current <= 16'h0277;
        repeat (5) @(posedge pclk);
        check(pitch_fine, 1'b1);
        check(pitch_stop, 1'b1);
        rd_chk(`PKC_OFF_RPM, 32'h0000_03E8);
        servo_current <= 16'h0276;
        repeat (5) @(posedge pclk);
        check(pitch_stop, 1'b0);
    endtask
    task automatic t_adj;
        press(1);
        rd_chk(`PKC_OFF_CTRL, 32'h0000_0001);
        check(dots_on, 1'b1);
        rpm_meas <= 16'h09C4;
        repeat (5) @(posedge pclk);
        check({sync_led, pitch_hold}, 2'b11);
        rpm_meas <= 16'h0960;
        repeat (5) @(posedge pclk);
        check(pitch_hold, 1'b1);
        turn(1'b1, 1);
        rd_chk(`PKC_OFF_SEL, 32'h0000_09C5);
        check({sync_led, pitch_hold}, 2'b00);
        rpm_meas <= 16'h09C5;
        repeat (5) @(posedge pclk);
        check(sync_led, 1'b1);
        rpm_meas <= 16'h0A8D;
        repeat (5) @(posedge pclk);
        check({sync_led, pitch_hold}, 2'b00);
        press(1);
        rd_chk(`PKC_OFF_CTRL, 32'h0000_0000);
        check(dots_on, 1'b0);
    endtask
    task automatic t_dim_burst;
        press(2);
        check(dim_on, 1'b1);
        press(3);
        check({dim_on, dots_on}, 2'b10);
        press(2);
        check(dim_on, 1'b0);
    endtask
    task automatic t_clamp;
        wr(`PKC_OFF_SEL, 32'h0000_0B54);
        rd_chk(`PKC_OFF_SEL, 32'h0000_0A8C);
        wr(`PKC_OFF_SEL, 32'h0000_0A8C);
        turn(1'b1, 1);
        rd_chk(`PKC_OFF_SEL, 32'h0000_0A8C);
        wr(`PKC_OFF_SEL, 32'h0000_09C4);
    endtask
    task automatic t_cal;
        press(4);
        rd_chk(`PKC_OFF_CTRL, 32'h0000_0002);
        check({display_value, state_led_green}, {16'h09C4, 1'b0});
        turn(1'b1, 201);
        check(display_value, 16'h0A8C);
        check(pitch_hold, 1'b1);
        // Go-around below the floor, so the redline floor is what stops the later turn
        turn(1'b0, 701);
        press(1);
        check(display_value, 16'h0A8C);
        turn(1'b1, 201);
        check(display_value, 16'h0B54);
        turn(1'b0, 901);
        check(display_value, 16'h07D0);
        turn(1'b1, 900);
        press(1);
        check(display_value, 16'h005A);
        press(1);
        turn(1'b1, 1);
        check(display_value, 16'h01F9);
        press(1);
        turn(1'b0, 1);
        check(display_value, 16'h0000);
        press(1);
        check(state_led_green, 1'b1);
        rd_chk(`PKC_OFF_CTRL, 32'h0000_0000);
        rd_chk(`PKC_OFF_GA, 32'h0000_07CF);
        rd_chk(`PKC_OFF_RL, 32'h0000_0B54);
        rd_chk(`PKC_OFF_TACH, 32'h0000_01F9);
        rd_chk(`PKC_OFF_TACHEN, 32'h0000_0000);
        check(display_value, 16'h09C4);
    endtask
    task automatic t_restore;
        logic seen_low;
        seen_low = 1'b0;
        knob.press_burst(5);
        repeat (70) begin
            @(posedge pclk);
            if (state_led_green === 1'b0) seen_low = 1'b1;
        end
        check(seen_low, 1'b1);
        rd_chk(`PKC_OFF_GA, 32'h0000_09C4);
        rd_chk(`PKC_OFF_RL, 32'h0000_0A8C);
        rd_chk(`PKC_OFF_TACH, 32'h0000_01F4);
        rd_chk(`PKC_OFF_TACHEN, 32'h0000_0001);
        check(state_led_green, 1'b1);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_gov();
        t_adj();
        t_dim_burst();
        t_clamp();
        t_cal();
        t_restore();
        complete_run();
    end
endmodule
